// *** rtl/bls_pkg.sv ***
// Package: constants, states and carriers for the burner lockout supervisor
`default_nettype none
package bls_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned TICK_MS           = 1;
  localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned POWERUP_MS        = 2500;
  localparam int unsigned HOLD_MS           = 3000;
  localparam int unsigned SAFETY_MS         = 5000;
  localparam int unsigned CODE_GAP_MS       = 10000;
  localparam int unsigned FLASH_ON_MS       = 600;
  localparam int unsigned FLASH_OFF_MS      = 1200;
  localparam int unsigned PREP_MS           = 15000;

  // ****************************************************************
  // Lockout causes
  // ****************************************************************
  localparam logic [1:0] CAUSE_NONE   = 2'h0;
  localparam logic [1:0] CAUSE_FLAME  = 2'h1;
  localparam logic [1:0] CAUSE_MANUAL = 2'h2;
  localparam logic [1:0] CAUSE_RESET  = CAUSE_NONE;
  localparam logic [2:0] FLASHES_FLAME  = 3'h4;
  localparam logic [2:0] FLASHES_MANUAL = 3'h2;

  // Supervisor states
  typedef enum logic [6:0] {
    ST_POWERUP  = 7'h01,
    ST_IDLE     = 7'h02,
    ST_PREP     = 7'h04,
    ST_SAFETY   = 7'h08,
    ST_RUN      = 7'h10,
    ST_UVLO     = 7'h20,
    ST_LOCKOUT  = 7'h40
  } bls_state_type;

  // Mains supervision inputs
  typedef struct packed {
    logic above_start;
    logic below_lock;
  } bls_mains_type;

  // Non-volatile store port
  typedef struct packed {
    logic       wr;
    logic [1:0] cause;
  } bls_nv_type;
endpackage : bls_pkg
`default_nettype wire

// *** rtl/bls_flash.sv ***
// Lockout lamp flash-code generator
`default_nettype none
module bls_flash #(
  parameter int unsigned GAP_TICKS = bls_pkg::CODE_GAP_MS,
  parameter int unsigned ON_TICKS  = bls_pkg::FLASH_ON_MS,
  parameter int unsigned OFF_TICKS = bls_pkg::FLASH_OFF_MS
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  // Control
  input  wire logic       i_tick,
  input  wire logic       i_enable,
  input  wire logic [2:0] i_flashes,
  // Lamp
  output logic            o_lamp
);
  initial
  begin
    if (GAP_TICKS < 1 || ON_TICKS < 1 || OFF_TICKS < 1 ||
        GAP_TICKS > 65535 || ON_TICKS > 65535 || OFF_TICKS > 65535)
      $error("bls_flash: tick counts must be at least one");
  end

  logic [15:0] cnt_reg;
  logic [2:0]  left_reg;
  logic        dark_reg;
  logic        lit_reg;

  // ****************************************************************
  // Steady light broken every gap by a counted burst of dark pulses
  // ****************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || !i_enable)
    begin
      cnt_reg  <= 16'h0000;
      left_reg <= 3'h0;
      dark_reg <= 1'b0;
      lit_reg  <= 1'b0;
    end
    else if (i_tick)
    begin
      lit_reg <= 1'b1;
      cnt_reg <= cnt_reg + 16'h0001;
      if (left_reg == 3'h0)
      begin
        dark_reg <= 1'b0;
        if (cnt_reg >= 16'(GAP_TICKS - 1))
        begin
          cnt_reg  <= 16'h0000;
          left_reg <= i_flashes;
          dark_reg <= (i_flashes != 3'h0);
        end
      end
      else if (dark_reg && cnt_reg >= 16'(ON_TICKS - 1))
      begin
        cnt_reg  <= 16'h0000;
        dark_reg <= 1'b0;
        left_reg <= left_reg - 3'h1;
      end
      else if (!dark_reg && cnt_reg >= 16'(OFF_TICKS - 1))
      begin
        cnt_reg  <= 16'h0000;
        dark_reg <= 1'b1;
      end
    end
  end

  // Lamp lit except during dark pulses; registered
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      o_lamp <= 1'b0;
    else
      o_lamp <= i_enable & lit_reg & ~dark_reg;
  end
endmodule // bls_flash
`default_nettype wire

// *** rtl/bls_supervisor.sv ***
// Burner lockout supervisor: start inhibit, undervoltage, flame and button lockout
//
// Overview of operation
// R1: No start-up begins unless mains is reported above the start threshold; the flame-loss restart from ST_RUN into ST_PREP does not check it.
// R2: Mains below the lockout threshold during start-up or running forces lockout.
// R3: After undervoltage lockout, restart automatically once mains is above threshold.
// R4: Fault lockout holds and shows its cause until internal or external reset.
// R5: Stored cause survives power loss; lockout re-entered about 2.5 s after power-up.
// R6: No flame at end of safety interval of a start attempt gives lockout.
// R7: Flame loss in running gives one restart; repeated failure locks out.
// R8: Installation must command a shutdown at least once every 24 hours.
// R9: Remote terminal input performs the same reset and lockout as the button.
// R10: A press during lockout clears it and launches a fresh start-up.
// R11: Button held over 3 s in start-up or running, then released, gives lockout.
// R12: Lockout lamp stays lit, broken every 10 s by a cause flash code.
// R13: Mains status comes as two synchronous digital flags from analog detection.
// R14: Cause is written to non-volatile store on lockout and read at power-up.
`default_nettype none
module bls_supervisor #(
  parameter int unsigned TICK_CYCLES = bls_pkg::TICK_CYCLES,
  parameter int unsigned POWERUP_T   = bls_pkg::POWERUP_MS,
  parameter int unsigned HOLD_T      = bls_pkg::HOLD_MS,
  parameter int unsigned SAFETY_T    = bls_pkg::SAFETY_MS,
  parameter int unsigned PREP_T      = bls_pkg::PREP_MS,
  parameter int unsigned GAP_T       = bls_pkg::CODE_GAP_MS,
  parameter int unsigned ON_T        = bls_pkg::FLASH_ON_MS,
  parameter int unsigned OFF_T       = bls_pkg::FLASH_OFF_MS
) (
  // Clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_n,
  // Mains supervision flags
  input  wire bls_pkg::bls_mains_type i_mains,
  // Heat demand, flame and buttons
  input  wire logic                   i_demand,
  input  wire logic                   i_flame,
  input  wire logic                   i_button,
  input  wire logic                   i_external_reset_lockout_button,
  // Non-volatile cause store
  input  wire logic [1:0]             i_nv_cause,
  output bls_pkg::bls_nv_type         o_nv,
  // Burner outputs
  output logic                        o_valve,
  output logic                        o_ignition,
  output logic                        o_alarm,
  output logic                        o_lamp,
  output logic [1:0]                  o_cause
);
  initial
  begin
    if (TICK_CYCLES < 2 || TICK_CYCLES > 65535 || SAFETY_T < 1 || PREP_T < 1 ||
        HOLD_T < 1 || POWERUP_T < 1 || POWERUP_T > 65535 || PREP_T > 65535 ||
        SAFETY_T > 65535 || HOLD_T > 65535)
      $error("bls_supervisor: timing parameters out of range");
  end

  bls_pkg::bls_state_type state_reg;
  logic [15:0] div_reg;
  logic        tick;
  logic [15:0] tmr_reg;
  logic [15:0] hold_reg;
  logic        btn_reg;
  logic        held_reg;
  logic        retry_reg;
  logic [1:0]  cause_reg;
  logic        press_rel;
  logic        manual_lock;
  logic        btn;
  logic [2:0]  flashes;

  // ****************************************************************
  // Timebase
  // ****************************************************************
  // Millisecond enable keeps all second-scale counters to 16 bits
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n || div_reg == 16'(TICK_CYCLES - 1))
      div_reg <= 16'h0000;
    else
      div_reg <= div_reg + 16'h0001;
  end
  assign tick = (div_reg == 16'(TICK_CYCLES - 1));

  // ****************************************************************
  // Button handling
  // ****************************************************************
  // R9: remote terminal merged
  assign btn = i_button | i_external_reset_lockout_button;

  // Hold time measured in ms; saturates so a very long hold still counts
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      btn_reg  <= 1'b0;
      hold_reg <= 16'h0000;
      held_reg <= 1'b0;
    end
    else
    begin
      btn_reg <= btn;
      if (!btn)
      begin
        hold_reg <= 16'h0000;
        held_reg <= 1'b0;
      end
      else if (tick && !held_reg)
      begin
        hold_reg <= hold_reg + 16'h0001;
        // R11: over hold time
        if (hold_reg >= 16'(HOLD_T))
          held_reg <= 1'b1;
      end
    end
  end
  assign press_rel   = btn_reg & ~btn;
  assign manual_lock = press_rel & held_reg;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= bls_pkg::ST_POWERUP;
      tmr_reg   <= 16'h0000;
      retry_reg <= 1'b0;
      cause_reg <= bls_pkg::CAUSE_NONE;
      o_nv      <= '0;
    end
    else
    begin
      o_nv.wr <= 1'b0;
      if (tick)
        tmr_reg <= tmr_reg + 16'h0001;
      case (state_reg)
        bls_pkg::ST_POWERUP:
        begin
          // R5: delayed re-entry of stored lockout
          // R14: cause read back
          if (tick && tmr_reg >= 16'(POWERUP_T - 1))
          begin
            tmr_reg   <= 16'h0000;
            cause_reg <= i_nv_cause;
            state_reg <= (i_nv_cause != bls_pkg::CAUSE_NONE) ?
                         bls_pkg::ST_LOCKOUT : bls_pkg::ST_IDLE;
          end
        end
        bls_pkg::ST_IDLE:
        begin
          tmr_reg <= 16'h0000;
          // R13: mains flags taken as synchronous levels
          // R1: start inhibit
          if (i_demand && i_mains.above_start && !i_mains.below_lock)
            state_reg <= bls_pkg::ST_PREP;
        end
        bls_pkg::ST_PREP, bls_pkg::ST_SAFETY, bls_pkg::ST_RUN:
        begin
          // R2: undervoltage lockout
          if (i_mains.below_lock)
            state_reg <= bls_pkg::ST_UVLO;
          // R11: manual lockout on release
          else if (manual_lock)
          begin
            state_reg <= bls_pkg::ST_LOCKOUT;
            cause_reg <= bls_pkg::CAUSE_MANUAL;
            o_nv      <= {1'b1, bls_pkg::CAUSE_MANUAL};
          end
          else if (!i_demand)
          begin
            state_reg <= bls_pkg::ST_IDLE;
            retry_reg <= 1'b0;
          end
          else if (state_reg == bls_pkg::ST_PREP)
          begin
            if (tick && tmr_reg >= 16'(PREP_T - 1))
            begin
              tmr_reg   <= 16'h0000;
              state_reg <= bls_pkg::ST_SAFETY;
            end
          end
          else if (state_reg == bls_pkg::ST_SAFETY)
          begin
            // R6: flame check at safety end
            if (tick && tmr_reg >= 16'(SAFETY_T - 1))
            begin
              tmr_reg <= 16'h0000;
              if (i_flame)
              begin
                state_reg <= bls_pkg::ST_RUN;
              end
              else
              begin
                state_reg <= bls_pkg::ST_LOCKOUT;
                cause_reg <= bls_pkg::CAUSE_FLAME;
                o_nv      <= {1'b1, bls_pkg::CAUSE_FLAME};
              end
            end
          end
          else
          begin
            // R7: one restart after flame loss
            tmr_reg <= 16'h0000;
            if (!i_flame)
            begin
              if (retry_reg)
              begin
                state_reg <= bls_pkg::ST_LOCKOUT;
                cause_reg <= bls_pkg::CAUSE_FLAME;
                o_nv      <= {1'b1, bls_pkg::CAUSE_FLAME};
              end
              else
              begin
                retry_reg <= 1'b1;
                state_reg <= bls_pkg::ST_PREP;
              end
            end
          end
        end
        bls_pkg::ST_UVLO:
        begin
          // R3: automatic restart, no reset needed
          tmr_reg   <= 16'h0000;
          retry_reg <= 1'b0;
          if (i_mains.above_start && !i_mains.below_lock)
            state_reg <= bls_pkg::ST_IDLE;
        end
        bls_pkg::ST_LOCKOUT:
        begin
          // R4: held until reset press
          // R10: press clears and restarts
          tmr_reg   <= 16'h0000;
          retry_reg <= 1'b0;
          if (press_rel)
          begin
            state_reg <= bls_pkg::ST_IDLE;
            cause_reg <= bls_pkg::CAUSE_NONE;
            o_nv      <= {1'b1, bls_pkg::CAUSE_RESET};
          end
        end
        default:
          state_reg <= bls_pkg::ST_POWERUP;
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Ignition only during the safety interval; valve open there and in running
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_valve    <= 1'b0;
      o_ignition <= 1'b0;
      o_alarm    <= 1'b0;
      o_cause    <= bls_pkg::CAUSE_NONE;
    end
    else
    begin
      o_valve    <= (state_reg == bls_pkg::ST_SAFETY) || (state_reg == bls_pkg::ST_RUN);
      o_ignition <= (state_reg == bls_pkg::ST_SAFETY);
      o_alarm    <= (state_reg == bls_pkg::ST_LOCKOUT);
      o_cause    <= cause_reg;
    end
  end

  assign flashes = (cause_reg == bls_pkg::CAUSE_MANUAL) ?
                   bls_pkg::FLASHES_MANUAL : bls_pkg::FLASHES_FLAME;

  // R12: lamp with periodic cause code
  bls_flash #(
    .GAP_TICKS (GAP_T),
    .ON_TICKS  (ON_T),
    .OFF_TICKS (OFF_T)
  ) u_flash (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_tick    (tick),
    .i_enable  (state_reg == bls_pkg::ST_LOCKOUT),
    .i_flashes (flashes),
    .o_lamp    (o_lamp)
  );
endmodule // bls_supervisor
`default_nettype wire

// *** bench/bls_supervisor_assertions.sv ***
// Port assertions for the burner lockout supervisor
`default_nettype none
module bls_chk #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic                   i_sys_clk,
  input wire logic                   i_rst_n,
  // Inputs watched
  input wire bls_pkg::bls_mains_type i_mains,
  input wire logic                   i_flame,
  input wire logic                   i_button,
  input wire logic                   i_external_reset_lockout_button,
  // Outputs watched
  input wire bls_pkg::bls_nv_type    o_nv,
  input wire logic                   o_valve,
  input wire logic                   o_ignition,
  input wire logic                   o_alarm,
  input wire logic                   o_lamp,
  input wire logic [1:0]             o_cause
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LAMP_MAX = 2 * TICK_CYCLES;
  wire logic btn;
  // Both buttons act alike, so they are watched as one
  assign btn = i_button | i_external_reset_lockout_button;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ****************
  // Properties
  // ****************
  property p_ign; o_ignition |-> o_valve; endproperty
  a_ign: assert property (p_ign) else $error("ignition without valve");
  property p_lock_off; o_alarm |-> !o_valve && !o_ignition; endproperty
  a_lock_off: assert property (p_lock_off) else $error("burner live in lockout");
  property p_uv; i_mains.below_lock && o_valve |-> ##2 !o_valve; endproperty
  a_uv: assert property (p_uv) else $error("valve kept on undervoltage");
  property p_run; $fell(o_ignition) && o_valve |-> $past(i_flame, 2); endproperty
  a_run: assert property (p_run) else $error("running without flame");
  // Three quiet samples rule out a release in flight
  property p_hold; o_alarm && !btn && !$past(btn) && !$past(btn, 2) |=> o_alarm; endproperty
  a_hold: assert property (p_hold) else $error("lockout left without reset");
  property p_clear;
    o_alarm && $fell(btn) |=> o_nv.wr && o_nv.cause == bls_pkg::CAUSE_RESET ##1 !o_alarm;
  endproperty
  a_clear: assert property (p_clear) else $error("release did not clear lockout");
  property p_nv; o_nv.wr |=> !o_nv.wr && o_cause == $past(o_nv.cause); endproperty
  a_nv: assert property (p_nv) else $error("stored cause mismatch");
  property p_lamp; $rose(o_alarm) |-> ##[1:LAMP_MAX] o_lamp; endproperty
  a_lamp: assert property (p_lamp) else $error("lamp not lit in lockout");
  c_lock: cover property ($rose(o_alarm));
  c_clear: cover property ($fell(o_alarm));
  c_run: cover property ($fell(o_ignition) && o_valve);
endmodule // bls_chk
bind bls_supervisor bls_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_mains(i_mains), .i_flame(i_flame),
  .i_button(i_button),
  .i_external_reset_lockout_button(i_external_reset_lockout_button),
  .o_nv(o_nv), .o_valve(o_valve), .o_ignition(o_ignition), .o_alarm(o_alarm),
  .o_lamp(o_lamp), .o_cause(o_cause)
);
`default_nettype wire

// *** bench/bls_far.sv ***
// Far-side model: mains monitor and flame detector
`default_nettype none
module bls_far (
  // Clock and stimulus
  input  wire logic                   i_sys_clk,
  input  wire logic [8:0]             i_volts,
  input  wire logic                   i_fuel,
  input  wire logic                   i_valve,
  // To the supervisor
  output bls_pkg::bls_mains_type      o_mains,
  output logic                        o_flame
);
  timeunit 1ns;
  timeprecision 1ns;
  // level flags at 187 V and 160 V
  assign o_mains.above_start = (i_volts > 9'h0bb);
  assign o_mains.below_lock  = (i_volts < 9'h0a0);
  // Flame only burns while gas flows, so a closed supply shows none
  always_ff @(posedge i_sys_clk)
    o_flame <= i_valve & i_fuel;
endmodule // bls_far
`default_nettype wire

// *** bench/bls_supervisor_tb.sv ***
// Testbench for the burner lockout supervisor
`default_nettype none
module bls_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  localparam int HOLD = 3;
  logic                   i_sys_clk = 1'b0;
  logic                   i_rst_n   = 1'b0;
  logic                   demand    = 1'b0;
  logic                   btn       = 1'b0;
  logic                   ext       = 1'b0;
  logic                   fuel      = 1'b1;
  logic [1:0]             nv_cause  = 2'h0;
  logic [8:0]             volts     = 9'h0c8;
  logic [1:0]             wr_cause  = 2'h3;
  bls_pkg::bls_mains_type mains;
  bls_pkg::bls_nv_type    nv;
  logic                   flame, valve, ign, alarm, lamp;
  logic [1:0]             cause;
  int                     fail_count = 0;
  int                     n_tests = 0;
  int                     cyc = 0;
  // Clock, 20 ns period
  always #10 i_sys_clk = ~i_sys_clk;
  // Short timers keep the run brief
  bls_supervisor #(.TICK_CYCLES(TK), .POWERUP_T(3), .HOLD_T(HOLD), .SAFETY_T(4),
    .PREP_T(5), .GAP_T(10), .ON_T(2), .OFF_T(2)) dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_mains(mains), .i_demand(demand),
    .i_flame(flame), .i_button(btn), .i_external_reset_lockout_button(ext),
    .i_nv_cause(nv_cause), .o_nv(nv), .o_valve(valve), .o_ignition(ign),
    .o_alarm(alarm), .o_lamp(lamp), .o_cause(cause));
  bls_far far (.i_sys_clk(i_sys_clk), .i_volts(volts), .i_fuel(fuel), .i_valve(valve),
    .o_mains(mains), .o_flame(flame));
  // Record every store write
  always @(posedge i_sys_clk)
    if (nv.wr === 1'b1)
      wr_cause = nv.cause;
  task automatic test_done;
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk_bit(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic chk_val(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", what, e, g);
    end
  endtask
  // Bounded wait for a level, then compare
  task automatic wt(input string what, ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++)
      @(negedge i_sys_clk);
    chk_bit(what, v, s);
  endtask
  task automatic do_reset(input logic [1:0] c);
    nv_cause = c;
    i_rst_n = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_n = 1'b1;
  endtask
  task automatic press(ref logic b, input int n);
    b = 1'b1;
    repeat (n) @(negedge i_sys_clk);
    b = 1'b0;
  endtask
  // Dark pulses between two long lit stretches
  task automatic flashes(output logic [7:0] n);
    int lit;
    bit armed;
    n = 0;
    lit = 0;
    armed = 0;
    for (int i = 0; i < 600; i++)
    begin
      @(negedge i_sys_clk);
      if (lamp === 1'b1)
        lit++;
      else
      begin
        if (lit > 0 && armed)
          n++;
        lit = 0;
      end
      if (lit > 6 * TK && armed && n > 0)
        break;
      if (lit > 6 * TK)
        armed = 1;
    end
  endtask
  // Main sequence
  initial
  begin
    logic [7:0] n;
    void'($urandom(32'hc3fd));
    do_reset(bls_pkg::CAUSE_NONE);
    // Start inhibited at 187 V and at a random level from 161 V to 186 V, with demand drawn at random each time
    for (int k = 0; k < 2; k++)
    begin
      demand = 1'($urandom);
      volts = k ? 9'($urandom_range(186, 161)) : 9'h0bb;
      repeat (12 * TK) @(negedge i_sys_clk);
      chk_bit("valve inhibited", 1'b0, valve);
    end
    demand = 1'b1;
    volts = 9'($urandom_range(250, 188));
    wt("valve start", valve, 1'b1, 14 * TK);
    wt("ignition end", ign, 1'b0, 6 * TK);
    chk_bit("running", 1'b1, valve);
    volts = 9'($urandom_range(159, 100));
    wt("undervoltage stop", valve, 1'b0, 3);
    repeat (3 * TK) @(negedge i_sys_clk);
    chk_bit("no alarm on undervoltage", 1'b0, alarm);
    volts = 9'($urandom_range(250, 188));
    wt("auto restart", valve, 1'b1, 14 * TK);
    wt("ignition end", ign, 1'b0, 6 * TK);
    fuel = 1'b0;
    wt("retry ignition", ign, 1'b1, 20 * TK);
    wt("flame lockout", alarm, 1'b1, 12 * TK);
    chk_val("cause", 8'(bls_pkg::CAUSE_FLAME), 8'(cause));
    chk_val("stored cause", 8'(bls_pkg::CAUSE_FLAME), 8'(wr_cause));
    flashes(n);
    chk_val("flame code", 8'(bls_pkg::FLASHES_FLAME), n);
    chk_bit("alarm held", 1'b1, alarm);
    fuel = 1'b1;
    press(ext, 2);
    wt("remote reset", alarm, 1'b0, 3);
    chk_val("cleared cause", 8'(bls_pkg::CAUSE_NONE), 8'(wr_cause));
    wt("fresh start", valve, 1'b1, 14 * TK);
    wt("ignition end", ign, 1'b0, 6 * TK);
    // Daily shutdown commanded by the installation, then a new start
    demand = 1'b0;
    wt("daily shutdown", valve, 1'b0, 3);
    chk_bit("no alarm on shutdown", 1'b0, alarm);
    demand = 1'b1;
    wt("start after shutdown", valve, 1'b1, 14 * TK);
    wt("ignition end", ign, 1'b0, 6 * TK);
    press(btn, (HOLD - 1) * TK);
    repeat (2 * TK) @(negedge i_sys_clk);
    chk_bit("short press ignored", 1'b0, alarm);
    press(ext, $urandom_range(HOLD + 4, HOLD + 2) * TK);
    wt("manual lockout", alarm, 1'b1, 4);
    chk_val("manual cause", 8'(bls_pkg::CAUSE_MANUAL), 8'(cause));
    flashes(n);
    chk_val("manual code", 8'(bls_pkg::FLASHES_MANUAL), n);
    press(btn, 2);
    wt("button reset", alarm, 1'b0, 3);
    do_reset(bls_pkg::CAUSE_MANUAL);
    repeat (2 * TK) @(negedge i_sys_clk);
    chk_bit("power-up wait", 1'b0, alarm);
    wt("lockout restored", alarm, 1'b1, 3 * TK);
    chk_val("restored cause", 8'(bls_pkg::CAUSE_MANUAL), 8'(cause));
    test_done();
  end
endmodule // bls_supervisor_tb
`default_nettype wire
